// file: bench/sdsel_host.sv
// Host side of the sense pin
`timescale 1ns/10ps
`default_nettype none
module sdsel_host (
    input wire logic clk,
    input wire logic [2:0] diag_sense_level,
    input wire logic diag_sense_oe
);
    task automatic sample(input int settle, output logic [2:0] seen);
        repeat (settle) @(posedge clk);
        #1;
        // Pull-down reads a released pin as no current
        seen = diag_sense_oe ? diag_sense_level : 3'h0;
    endtask : sample
endmodule : sdsel_host
`default_nettype wire

// file: bench/sdsel_top_assertions.sv
// Port checks for the sense selector
`timescale 1ns/10ps
`default_nettype none
module sdsel_checker
    import sdsel_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [2:0] diag_sense_level,
    input wire logic diag_sense_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // Only lane 0 carries the enable bit
    sequence s_ctrl_off;
        s_wr_taken ##0 (s_axi_awaddr == REG_CTRL && s_axi_wstrb[0] && !s_axi_wdata[0]);
    endsequence
    a_oe_follows_level: assert property (diag_sense_oe == (diag_sense_level != SDSEL_HIZ))
        else $error("sense enable disagrees with level");
    a_level_code_legal: assert property (diag_sense_level inside {3'h0, 3'h1, 3'h2, 3'h3, 3'h6})
        else $error("sense level code not defined");
    a_disable_gives_hiz: assert property (s_ctrl_off |-> ##[1:4] (diag_sense_level == SDSEL_HIZ))
        else $error("sense pin driven while disabled");
    a_write_answer: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    a_unmapped_decerr: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > REG_LEVEL
        |=> s_axi_rresp == AXI_DECERR)
        else $error("unmapped read not refused");
endmodule : sdsel_checker
bind sdsel_top sdsel_checker sdsel_checker_inst (.clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .diag_sense_level, .diag_sense_oe);
`default_nettype wire

// file: bench/switch_diag_sense_select_test.sv
// Register level test of the sense selector
`timescale 1ns/10ps
`default_nettype none
module switch_diag_sense_select_test
    import sdsel_pkg::*;
;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, diag_sense_oe, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [2:0] diag_sense_level, seen;
    sdsel_level_t expv [4] = '{SDSEL_PROP, SDSEL_OPEN, SDSEL_LEAK, SDSEL_HIZ};
    int err_count = 0, checked = 0, n;
    always #25 clk = ~clk;
    sdsel_top #(.HOLD_CYC(20), .CLEAR_CYC(40), .LIMIT(3)) sdsel_top_inst (.clk, .srst, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .diag_sense_level, .diag_sense_oe, .irq);
    sdsel_host sdsel_host_inst (.clk, .diag_sense_level, .diag_sense_oe);
    task automatic complete_run;
        if (err_count == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : complete_run
    task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
        // A hung handshake ends the run here
        if (n >= 100) begin
            err_count++;
            complete_run();
        end
    endtask : check_word
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        n = 0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge clk);
            n++;
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && n < 100);
        s_axi_bready <= 1'b0;
        check_word("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    endtask : axi_wr
    task automatic reg_chk(input logic [7:0] a, input logic [1:0] er, input logic [31:0] m, input logic [31:0] e);
        n = 0;
        @(posedge clk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge clk);
            n++;
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && n < 100);
        s_axi_rready <= 1'b0;
        check_word("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
        check_word($sformatf("reg %h", a), e, s_axi_rdata & m);
    endtask : reg_chk
    task automatic pin(input int w, input logic [2:0] e);
        sdsel_host_inst.sample(w, seen);
        check_word("sense pin", {29'h0, e}, {29'h0, seen});
    endtask : pin
    initial begin
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        reg_chk(REG_CTRL, AXI_OKAY, 32'hffff_ffff, CTRL_RESET);
        reg_chk(REG_IRQ_MASK, AXI_OKAY, 32'hffff_ffff, MASK_RESET);
        reg_chk(REG_STATUS, AXI_OKAY, 32'hffff_ffff, 32'h0000_000f);
        reg_chk(REG_LEVEL, AXI_OKAY, 32'hffff_ffff, 32'h0);
        reg_chk(8'h18, AXI_DECERR, 32'h0, 32'h0);
        axi_wr(REG_STATUS, 32'h0, AXI_DECERR);
        for (int c = 0; c < 4; c++) begin
            axi_wr(REG_CTRL, 32'h0000_0351 | 32'(c << 1), AXI_OKAY);
            pin(2, expv[c]);
            reg_chk(REG_LEVEL, AXI_OKAY, 32'hf, {28'h0, expv[c] != SDSEL_HIZ, expv[c]});
        end
        axi_wr(REG_FAULT_SET, 32'h2, AXI_OKAY);
        axi_wr(REG_CTRL, 32'h0000_0353, AXI_OKAY);
        pin(2, SDSEL_FAULT);
        reg_chk(REG_STATUS, AXI_OKAY, 32'hf, 32'hd);
        axi_wr(REG_CTRL, 32'h0000_0352, AXI_OKAY);
        pin(2, SDSEL_HIZ);
        axi_wr(REG_CTRL, 32'h0000_0353, AXI_OKAY);
        pin(2, SDSEL_OPEN);
        axi_wr(REG_CTRL, 32'h0000_0341, AXI_OKAY);
        axi_wr(REG_FAULT_SET, 32'h1, AXI_OKAY);
        pin(2, SDSEL_FAULT);
        axi_wr(REG_CTRL, 32'h0000_0351, AXI_OKAY);
        pin(2, SDSEL_FAULT);
        pin(30, SDSEL_PROP);
        axi_wr(REG_CTRL, 32'h0000_1351, AXI_OKAY);
        pin(2, SDSEL_FAULT);
        axi_wr(REG_CTRL, 32'h0000_0355, AXI_OKAY);
        axi_wr(REG_FAULT_SET, 32'h4, AXI_OKAY);
        pin(2, SDSEL_FAULT);
        repeat (2) axi_wr(REG_FAULT_SET, 32'h4, AXI_OKAY);
        pin(30, SDSEL_FAULT);
        reg_chk(REG_STATUS, AXI_OKAY, 32'h400, 32'h400);
        reg_chk(REG_IRQ_STAT, AXI_OKAY, 32'h4, 32'h4);
        check_word("irq", 32'h0, {31'h0, irq});
        axi_wr(REG_IRQ_MASK, 32'h4, AXI_OKAY);
        repeat (2) @(posedge clk);
        check_word("irq", 32'h1, {31'h0, irq});
        axi_wr(REG_IRQ_STAT, 32'h4, AXI_OKAY);
        repeat (2) @(posedge clk);
        check_word("irq", 32'h0, {31'h0, irq});
        complete_run();
    end
endmodule : switch_diag_sense_select_test
`default_nettype wire

// file: hdl/sdsel_chan.sv
// Per-channel fault memory and fault hold timing
`timescale 1ns/10ps
`default_nettype none
module sdsel_chan
    import sdsel_pkg::*;
#(
    parameter int HOLD_CYC = FAULT_HOLD_CYC,
    parameter int CLEAR_CYC = CLEAR_DELAY_CYC,
    parameter int LIMIT = RETRY_LIMIT
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic fault_evt,
    input wire logic chan_on,
    input wire logic retry_run,
    input wire logic den_pulse,
    output logic cnt_zero,
    output logic fault_show,
    output logic at_limit
);
    logic [7:0] retries_q;
    logic [31:0] hold_q;
    logic [31:0] clr_q;
    logic on_q;
    logic run_q;

    assign cnt_zero = (retries_q == 8'h00);
    assign at_limit = (retries_q >= 8'(LIMIT));

    always_ff @(posedge clk) begin
        if (srst || den_pulse || (clr_q == 32'(CLEAR_CYC) && !cnt_zero)) begin
            retries_q <= 8'h00;
        end else if (fault_evt && !at_limit) begin
            retries_q <= retries_q + 8'h01;
        end
    end

    // Clear delay runs while off and no fault
    always_ff @(posedge clk) begin
        if (srst || fault_evt || cnt_zero || chan_on) begin
            clr_q <= 32'h0;
        end else if (clr_q != 32'(CLEAR_CYC)) begin
            clr_q <= clr_q + 32'h1;
        end
    end

    // hold restarts each time the channel may restart
    always_ff @(posedge clk) begin
        on_q <= srst ? 1'b0 : chan_on;
        run_q <= srst ? 1'b0 : retry_run;
        if (srst) begin
            hold_q <= 32'h0;
        end else if (chan_on && (fault_evt || ((!on_q || (run_q && !retry_run)) && !cnt_zero))) begin
            hold_q <= 32'(HOLD_CYC);
        end else if (hold_q != 32'h0) begin
            hold_q <= hold_q - 32'h1;
        end
    end

    always_comb begin
        fault_show = 1'b0;
        if (!cnt_zero) begin
            if (!chan_on || retry_run || at_limit || hold_q != 32'h0) begin
                fault_show = 1'b1;
            end
        end
    end
endmodule : sdsel_chan
`default_nettype wire

// file: hdl/sdsel_top.sv
// Diagnosis sense selector with AXI4-Lite registers
// Operation
// - Proportional sense only when on, below threshold, enabled, no fault.
// - Hard failure present or uncleared drives fault level.
// - Retry counter off reset shows fault for selected enabled channel while off, retrying, at limit or in hold time.
// - On with retries under limit, fault held for hold time after restart.
// - Fault reported while retry timer runs.
// - At retry limit fault held until clear delay or enable pulse.
// - Off with counter not reset reports fault.
// - Off, enabled, selected: open-load level when voltage at or below threshold.
// - Open-load and fault levels never overlap.
// - Enable low puts sense pin in high impedance.
// - Enable high routes channel chosen by two binary select bits.
// - Fault hold time typically 500 microseconds.
`timescale 1ns/10ps
`default_nettype none
module sdsel_top
    import sdsel_pkg::*;
#(
    parameter int HOLD_CYC = FAULT_HOLD_CYC,
    parameter int CLEAR_CYC = CLEAR_DELAY_CYC,
    parameter int LIMIT = RETRY_LIMIT
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [2:0] diag_sense_level,
    output logic diag_sense_oe,
    output logic irq
);
    logic [31:0] ctrl_q;
    logic [31:0] mask_q;
    logic [3:0] stat_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic aw_have_q;
    logic w_have_q;
    logic [NUM_CHAN-1:0] fault_evt;
    logic [NUM_CHAN-1:0] cnt_zero;
    logic [NUM_CHAN-1:0] fault_show;
    logic [NUM_CHAN-1:0] at_limit;
    logic [NUM_CHAN-1:0] at_limit_q;
    logic den_q;
    logic den_pulse;
    logic wr_go;
    logic [31:0] wmask;
    logic diag_enable_pin;
    logic chan_select_bit0;
    logic chan_select_bit1;
    logic [1:0] sel;
    logic [NUM_CHAN-1:0] chan_on;
    logic [NUM_CHAN-1:0] ol_below;
    logic [NUM_CHAN-1:0] retry_run;
    sdsel_level_t level_d;
    logic [NUM_CHAN-1:0][2:0] chan_level;
    logic aw_take;
    logic w_take;
    logic ar_take;
    logic wr_ctrl;
    logic wr_mask;
    logic wr_stat;
    logic wr_fault;
    logic [NUM_CHAN-1:0] stat_set;
    logic [1:0] bresp_d;
    logic [31:0] rdata_d;
    logic [1:0] rresp_d;

    assign diag_enable_pin = ctrl_q[CTRL_EN_BIT];
    assign chan_select_bit0 = ctrl_q[CTRL_SEL_LSB];
    assign chan_select_bit1 = ctrl_q[CTRL_SEL_LSB+1];
    assign sel = {chan_select_bit1, chan_select_bit0};
    assign chan_on = ctrl_q[CTRL_ON_LSB +: NUM_CHAN];
    assign ol_below = ctrl_q[CTRL_OL_LSB +: NUM_CHAN];
    assign retry_run = ctrl_q[CTRL_RUN_LSB +: NUM_CHAN];
    assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;
    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take = s_axi_wvalid && s_axi_wready;
    assign ar_take = s_axi_arvalid && s_axi_arready;

    // One strobe per register keeps the address decode in one place
    assign wr_ctrl = wr_go && (awaddr_q == REG_CTRL);
    assign wr_mask = wr_go && (awaddr_q == REG_IRQ_MASK);
    // Only lane 0 holds status bits
    assign wr_stat = wr_go && (awaddr_q == REG_IRQ_STAT) && wstrb_q[0];
    assign wr_fault = wr_go && (awaddr_q == REG_FAULT_SET);

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_lane
            assign wmask[g*8 +: 8] = wstrb_q[g] ? 8'hff : 8'h00;
        end
    endgenerate

    // Fault injection stands in for the protection logic
    assign fault_evt = wr_fault ? wdata_q[NUM_CHAN-1:0] : '0;
    // Enable falling edge counts as the reset pulse
    assign den_pulse = den_q && !diag_enable_pin;

    always_ff @(posedge clk) begin
        den_q <= srst ? 1'b0 : diag_enable_pin;
    end

    generate
        for (g = 0; g < NUM_CHAN; g++) begin : g_chan
            sdsel_chan #(
                .HOLD_CYC(HOLD_CYC),
                .CLEAR_CYC(CLEAR_CYC),
                .LIMIT(LIMIT)
            ) u_chan (
                .clk(clk),
                .srst(srst),
                .fault_evt(fault_evt[g]),
                .chan_on(chan_on[g]),
                .retry_run(retry_run[g]),
                .den_pulse(den_pulse),
                .cnt_zero(cnt_zero[g]),
                .fault_show(fault_show[g]),
                .at_limit(at_limit[g])
            );
        end
    endgenerate

    // Per-channel level, fault on top
    generate
        for (g = 0; g < NUM_CHAN; g++) begin : g_level
            always_comb begin
                if (fault_show[g]) begin
                    chan_level[g] = SDSEL_FAULT;
                end else if (chan_on[g]) begin
                    chan_level[g] = ol_below[g] ? SDSEL_PROP : SDSEL_LEAK;
                end else if (ol_below[g]) begin
                    chan_level[g] = SDSEL_OPEN;
                end else begin
                    chan_level[g] = SDSEL_HIZ;
                end
            end
        end
    endgenerate

    // Selected channel onto the pin
    always_comb begin
        if (!diag_enable_pin) begin
            level_d = SDSEL_HIZ;
        end else begin
            level_d = sdsel_level_t'(chan_level[sel]);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            diag_sense_level <= SDSEL_HIZ;
            diag_sense_oe <= 1'b0;
        end else begin
            diag_sense_level <= level_d;
            diag_sense_oe <= (level_d != SDSEL_HIZ);
        end
    end

    // Write channel capture, address and data in either order
    always_ff @(posedge clk) begin
        if (srst) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
        end else begin
            if (aw_take) begin
                aw_have_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_have_q <= 1'b0;
            end
            if (w_take) begin
                w_have_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end else if (wr_go) begin
                w_have_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            // Ready stays low while a word waits, so one write at a time
            s_axi_awready <= !aw_have_q && !aw_take && !s_axi_bvalid;
            s_axi_wready <= !w_have_q && !w_take && !s_axi_bvalid;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= AXI_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= bresp_d;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Status and level are read-only, so writes to them are refused
    always_comb begin
        case (awaddr_q)
            REG_CTRL, REG_IRQ_STAT, REG_IRQ_MASK, REG_FAULT_SET: begin
                bresp_d = AXI_OKAY;
            end
            default: begin
                bresp_d = AXI_DECERR;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl_q <= CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_q <= (ctrl_q & ~wmask) | (wdata_q & wmask);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            mask_q <= MASK_RESET;
        end else if (wr_mask) begin
            mask_q <= (mask_q & ~wmask) | (wdata_q & wmask);
        end
    end

    // Event: channel reaches its retry limit
    always_ff @(posedge clk) begin
        if (srst) begin
            at_limit_q <= '0;
        end else begin
            at_limit_q <= at_limit;
        end
    end
    assign stat_set = at_limit & ~at_limit_q;

    // Sticky per channel; a set in the clearing cycle wins
    generate
        for (g = 0; g < NUM_CHAN; g++) begin : g_stat
            always_ff @(posedge clk) begin
                if (srst) begin
                    stat_q[g] <= 1'b0;
                end else if (stat_set[g]) begin
                    stat_q[g] <= 1'b1;
                end else if (wr_stat && wdata_q[g]) begin
                    stat_q[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // Level interrupt, one cycle behind status and mask
    always_ff @(posedge clk) begin
        irq <= srst ? 1'b0 : |(stat_q & mask_q[3:0]);
    end

    // Read mux; unmapped words answer with a decode error
    always_comb begin
        rdata_d = 32'h0;
        rresp_d = AXI_OKAY;
        case (s_axi_araddr)
            REG_CTRL: begin
                rdata_d = ctrl_q;
            end
            REG_STATUS: begin
                rdata_d = {20'h0, at_limit, fault_show, cnt_zero};
            end
            REG_IRQ_STAT: begin
                rdata_d = {28'h0, stat_q};
            end
            REG_IRQ_MASK: begin
                rdata_d = mask_q;
            end
            // Event register reads back as zero
            REG_FAULT_SET: begin
                rdata_d = 32'h0;
            end
            REG_LEVEL: begin
                rdata_d = {28'h0, diag_sense_oe, diag_sense_level};
            end
            default: begin
                rresp_d = AXI_DECERR;
            end
        endcase
    end

    // Read channel, one cycle answer
    always_ff @(posedge clk) begin
        if (srst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= AXI_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !ar_take;
            if (ar_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rdata_d;
                s_axi_rresp <= rresp_d;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule : sdsel_top
`default_nettype wire

// file: pkg/sdsel_pkg.sv
// Constants and types for the diagnosis sense selector
package sdsel_pkg;
    localparam int NUM_CHAN = 4;
    localparam int CLK_FREQ_MHZ = 20;
    // Fault hold time in microseconds
    localparam int FAULT_HOLD_US = 500;
    localparam int FAULT_HOLD_CYC = FAULT_HOLD_US * CLK_FREQ_MHZ;
    // Counter clear delay in microseconds, value arbitrary
    localparam int CLEAR_DELAY_US = 1000;
    localparam int CLEAR_DELAY_CYC = CLEAR_DELAY_US * CLK_FREQ_MHZ;
    localparam int RETRY_LIMIT = 8;

    // Register byte addresses
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_IRQ_STAT = 8'h08;
    localparam logic [7:0] REG_IRQ_MASK = 8'h0c;
    localparam logic [7:0] REG_FAULT_SET = 8'h10;
    localparam logic [7:0] REG_LEVEL = 8'h14;

    // Control field positions
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_SEL_LSB = 1;
    localparam int CTRL_ON_LSB = 4;
    localparam int CTRL_OL_LSB = 8;
    localparam int CTRL_RUN_LSB = 12;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] MASK_RESET = 32'h0000_0000;

    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_DECERR = 2'h3;

    // Sense pin level encoding, fault outranks the others
    typedef enum logic [2:0] {
        SDSEL_HIZ = 3'h0,
        SDSEL_PROP = 3'h1,
        SDSEL_LEAK = 3'h3,
        SDSEL_OPEN = 3'h2,
        SDSEL_FAULT = 3'h6
    } sdsel_level_t;
endpackage : sdsel_pkg
